//--- include/port_cfg_pkg.sv
/*
  Constants for the host port ownership and write-flush control block.
  Assumes an APB slave with 32-bit data; offsets are byte addresses.
*/
package port_cfg_pkg;
  // Register offsets
  localparam logic [7:0] CONFIG_OFS    = 8'h00;
  localparam logic [7:0] CTRL_OFS      = 8'h04;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h0c;
  localparam logic [7:0] STATUS_OFS    = 8'h10;
  localparam logic [7:0] ADDR_OFS      = 8'h14;
  // Config field positions
  localparam int CTL_OWNER_BIT  = 9;
  localparam int ADR_OWNER_BIT  = 8;
  localparam int TIMEOUT_LSB    = 0;
  localparam int TIMEOUT_W      = 8;
  localparam logic [7:0] TIMEOUT_RST = 8'h80;
  localparam logic       OWNER_RST   = 1'b0;
  // Control register layout
  localparam int HOST_IRQ_BIT   = 2;
  localparam logic [7:0] CTRL_RST = 8'h08;
  localparam logic [7:0] CTRL_WMASK = 8'h01;
  // Burst size in words
  localparam logic [2:0] BURST_WORDS = 3'h4;
  // Interrupt status bits
  localparam int EV_BURST = 0;
  localparam int EV_FLUSH = 1;
  localparam int EV_DENY  = 2;
  localparam int EV_W     = 3;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_WAIT  = 2'b01,
    ST_DRAIN = 2'b10
  } drain_state_t;
endpackage : port_cfg_pkg

//--- hw/host_port_ownership_and_flush_ctl.sv
/*
  Ownership and write-FIFO flush control for the host port.
  Assumes pclk at 200 MHz, host-side signals already in the pclk domain,
  and a write FIFO that reports word arrivals and accepts drain pulses.
  Software is trusted to keep the reserved config bits at zero and to
  set the flush timeout once, with the write FIFO empty; neither is checked
  here, and a late timeout change only moves the next flush point.
  Host side strobes are expected low while reset is held.
*/
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module host_port_ownership_and_flush_ctl
  import port_cfg_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              host_ctrl_wr,
  input  wire logic [7:0]        host_ctrl_wdata,
  input  wire logic              host_addr_wr,
  input  wire logic [ADDR_W-1:0] host_addr_wdata,
  input  wire logic              wfifo_push,
  output logic                   dma_burst,
  output logic                   dma_flush,
  output logic                   host_irq_n,
  output logic      [7:0]        port_control_reg,
  output logic      [ADDR_W-1:0] port_address_regs,
  output logic                   irq
);
  import port_cfg_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Bus decode
  // Bus strobes and decode
  logic                 apb_wr;
  logic                 apb_rd;
  logic                 mapped;

  // Configuration fields, held apart rather than as one word
  logic                 control_reg_owner_sel;
  logic                 address_reg_owner_sel;
  logic [7:0]           write_fifo_flush_timeout;
  // Shared register copies and interrupt bookkeeping
  logic [7:0]           ctrl_q;
  logic [ADDR_W-1:0]    addr_q;
  logic [EV_W-1:0]      stat_q;
  logic [EV_W-1:0]      mask_q;
  logic [EV_W-1:0]      ev;
  // Drain sequencer: words waiting, idle timer, state
  logic [2:0]           words_q;
  logic [7:0]           tmr_q;
  drain_state_t         state_q;
  // Ownership arbitration
  logic                 cpu_ctrl_wr;
  logic                 cpu_addr_wr;
  logic                 cpu_wins_ctrl;
  logic                 host_wins_ctrl;
  logic                 deny;

  // Access phase strobes; with no wait states every access ends here
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && penable && !pwrite;

  // Every offset that answers without an error
  assign mapped = (paddr == CONFIG_OFS) || (paddr == CTRL_OFS) ||
                  (paddr == IRQ_STAT_OFS) || (paddr == IRQ_MASK_OFS) ||
                  (paddr == STATUS_OFS) || (paddr == ADDR_OFS);

  // CPU side writes of the two shared registers
  assign cpu_ctrl_wr = apb_wr && (paddr == CTRL_OFS);
  assign cpu_addr_wr = apb_wr && (paddr == ADDR_OFS);

  // Ownership decides who may write the plain control bit, bit 0
  assign cpu_wins_ctrl  = control_reg_owner_sel;
  assign host_wins_ctrl = !control_reg_owner_sel;

  // Any write from the side without ownership is dropped, save the shared interrupt bit, and reported,
  // so software can spot a wrongly set owner field from the status bit.
  // A write that also carries the shared interrupt bit still counts here.
  assign deny = (cpu_ctrl_wr && !cpu_wins_ctrl) || (host_ctrl_wr && !host_wins_ctrl) ||
                (cpu_addr_wr && !address_reg_owner_sel) ||
                (host_addr_wr && address_reg_owner_sel);

  ////////////////////////////////////////////////////////////////////
  // Configuration register
  // Only the two owner bits and the timeout are stored; the reserved
  // upper bits read back as zero whatever software wrote there.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      control_reg_owner_sel    <= OWNER_RST;
      address_reg_owner_sel    <= OWNER_RST;
      write_fifo_flush_timeout <= TIMEOUT_RST;
    end else if (apb_wr && paddr == CONFIG_OFS) begin
      control_reg_owner_sel    <= pwdata[CTL_OWNER_BIT];
      address_reg_owner_sel    <= pwdata[ADR_OWNER_BIT];
      write_fifo_flush_timeout <= pwdata[TIMEOUT_LSB +: TIMEOUT_W];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Port control register, host interrupt bit open to both sides
  // Only bit 0 is a plain owner bit here; bit 3 is a constant one and the
  // remaining bits keep their reset value. The interrupt bit is shared, and
  // a host clear wins over a CPU set in the same cycle so the pin is freed.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
    end else begin
      // Owner writes the plain bit, bit 0, only
      if (cpu_ctrl_wr && cpu_wins_ctrl) begin
        ctrl_q[0] <= pwdata[0] & CTRL_WMASK[0];
      end else if (host_ctrl_wr && host_wins_ctrl) begin
        ctrl_q[0] <= host_ctrl_wdata[0] & CTRL_WMASK[0];
      end
      // Host one clears, CPU one sets; zero has no effect
      if (host_ctrl_wr && host_ctrl_wdata[HOST_IRQ_BIT]) begin
        ctrl_q[HOST_IRQ_BIT] <= 1'b0;
      end else if (cpu_ctrl_wr && pwdata[HOST_IRQ_BIT]) begin
        ctrl_q[HOST_IRQ_BIT] <= 1'b1;
      end
    end
  end

  // Pin is active low, inverse of the bit
  // Registered so the pin never glitches on a register update
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      host_irq_n <= 1'b1;
    end else begin
      host_irq_n <= !ctrl_q[HOST_IRQ_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Port address register, owner only
  // Host writes arrive as one-cycle pulses already on this clock; when
  // both sides write at once only the owner's value can land.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_q <= '0;
    end else if (cpu_addr_wr && address_reg_owner_sel) begin
      addr_q <= pwdata[ADDR_W-1:0];
    end else if (host_addr_wr && !address_reg_owner_sel) begin
      addr_q <= host_addr_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Write FIFO drain: full bursts, or flush after idle timeout
  // Idle waits for the first word. Wait counts words and idle cycles:
  // the fourth word fires a burst at once, and the timer restarts on
  // each word so a steady trickle is never flushed early. Once the timer
  // reaches the programmed value the next cycle issues the flush pulse.
  // A timeout of zero flushes two cycles after the last word. A word that
  // arrives during the flush cycle opens the next partial burst.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q   <= ST_IDLE;
      words_q   <= 3'h0;
      tmr_q     <= 8'h00;
      dma_burst <= 1'b0;
      dma_flush <= 1'b0;
    end else begin
      dma_burst <= 1'b0;
      dma_flush <= 1'b0;
      case (state_q)
        // Nothing waiting in the write FIFO
        ST_IDLE: begin
          if (wfifo_push) begin
            words_q <= 3'h1;
            tmr_q   <= 8'h00;
            state_q <= ST_WAIT;
          end
        end
        // Count words; burst on the fourth, else wait out the timer
        ST_WAIT: begin
          if (wfifo_push) begin
            tmr_q <= 8'h00;
            if (words_q + 3'h1 == BURST_WORDS) begin
              dma_burst <= 1'b1;
              words_q   <= 3'h0;
              state_q   <= ST_IDLE;
            end else begin
              words_q <= words_q + 3'h1;
            end
          end else if (tmr_q >= write_fifo_flush_timeout) begin
            state_q <= ST_DRAIN;
          end else begin
            tmr_q <= tmr_q + 8'h01;
          end
        end
        // One cycle: pulse the flush and take any word arriving now
        ST_DRAIN: begin
          dma_flush <= 1'b1;
          words_q   <= wfifo_push ? 3'h1 : 3'h0;
          tmr_q     <= 8'h00;
          state_q   <= wfifo_push ? ST_WAIT : ST_IDLE;
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Interrupt status, write one to clear, set wins
  // Events are the one-cycle drain pulses and the denied-write strobe;
  // an event in the same cycle as its clear keeps the bit set.
  // Event order matches the status bit positions
  assign ev = {deny, dma_flush, dma_burst};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      // Mask is plain read-write
      if (apb_wr && paddr == IRQ_MASK_OFS) begin
        mask_q <= pwdata[EV_W-1:0];
      end
      if (apb_wr && paddr == IRQ_STAT_OFS) begin
        stat_q <= (stat_q & ~pwdata[EV_W-1:0]) | ev;
      end else begin
        stat_q <= stat_q | ev;
      end
    end
  end

  // Level interrupt, one cycle behind the status bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(stat_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Register views to the outside
  // Copies for the host side logic; one cycle late, which is harmless
  // since the host only reads them between its own write pulses
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_control_reg  <= CTRL_RST;
      port_address_regs <= '0;
    end else begin
      port_control_reg  <= ctrl_q;
      port_address_regs <= addr_q;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // APB answer: zero wait, read data registered at setup
  // The setup cycle alone decides the answer: ready rises for the access
  // cycle, an unmapped offset also raises the error, and read data is
  // captured from the registers as they stand during setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      if (psel && !penable && !pwrite) begin
        // Reserved bits of every register read as zero
        case (paddr)
          CONFIG_OFS:   prdata <= {22'h0, control_reg_owner_sel, address_reg_owner_sel,
                                   write_fifo_flush_timeout};
          CTRL_OFS:     prdata <= {24'h0, ctrl_q};
          IRQ_STAT_OFS: prdata <= {29'h0, stat_q};
          IRQ_MASK_OFS: prdata <= {29'h0, mask_q};
          STATUS_OFS:   prdata <= {27'h0, state_q, words_q};
          ADDR_OFS:     prdata <= 32'(addr_q);
          default:      prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Reads have no side effects; the strobe is kept for clarity only
  logic unused_rd;
  assign unused_rd = apb_rd;
endmodule : host_port_ownership_and_flush_ctl
`default_nettype wire

//--- tb/host_model.sv
/* Host processor model: control and address writes, FIFO pushes.
   Assumes the bench calls its tasks right after a clock edge. */
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic        pclk,
  output logic             host_ctrl_wr,
  output logic [7:0]       host_ctrl_wdata,
  output logic             host_addr_wr,
  output logic [31:0]      host_addr_wdata,
  output logic             wfifo_push
);
  // Idle values
  initial begin
    host_ctrl_wr = 1'b0;
    host_addr_wr = 1'b0;
    wfifo_push = 1'b0;
    host_ctrl_wdata = 8'h5a;
    host_addr_wdata = 32'h0;
  end
  // One-cycle writes; data inverts once released
  task automatic ctl(input logic [7:0] d);
    @(posedge pclk);
    host_ctrl_wr <= 1'b1;
    host_ctrl_wdata <= d;
    @(posedge pclk);
    host_ctrl_wr <= 1'b0;
    host_ctrl_wdata <= ~d;
  endtask : ctl
  task automatic adr(input logic [31:0] d);
    @(posedge pclk);
    host_addr_wr <= 1'b1;
    host_addr_wdata <= d;
    @(posedge pclk);
    host_addr_wr <= 1'b0;
    host_addr_wdata <= ~d;
  endtask : adr
  // Back-to-back word arrivals
  task automatic push(input int n);
    @(posedge pclk);
    wfifo_push <= 1'b1;
    repeat (n) @(posedge pclk);
    wfifo_push <= 1'b0;
  endtask : push
endmodule : host_model
`default_nettype wire

//--- tb/port_cfg_checker.sv
/* Port checker for the ownership and flush block.
   Bound to the design top; sees its ports only. */
`timescale 1ns/1ps
`default_nettype none
module port_cfg_checker
  import port_cfg_pkg::*;
#(parameter int ADDR_W = 32) (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [7:0]        paddr,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              host_ctrl_wr,
  input wire logic [7:0]        host_ctrl_wdata,
  input wire logic              host_addr_wr,
  input wire logic              wfifo_push,
  input wire logic              dma_burst,
  input wire logic              dma_flush,
  input wire logic              host_irq_n,
  input wire logic [7:0]        port_control_reg,
  input wire logic [ADDR_W-1:0] port_address_regs
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic apb_wr = psel && penable && pready && pwrite;
  logic [1:0] own_q;
  // CPU owner bits seen from config writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      own_q <= 2'h0;
    else if (apb_wr && paddr == CONFIG_OFS)
      own_q <= pwdata[CTL_OWNER_BIT:ADR_OWNER_BIT];
  end
  //////////////////////////////
  property p_ready; psel && !penable |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  property p_err; pslverr && !pwrite |-> pready && prdata == 32'h0; endproperty
  a_err: assert property (p_err) else $error("bad error read");
  property p_irq_set; apb_wr && paddr == CTRL_OFS && pwdata[HOST_IRQ_BIT]
    && !host_ctrl_wr |=> ##1 !host_irq_n; endproperty
  a_irq_set: assert property (p_irq_set) else $error("pin not low");
  property p_irq_clr; host_ctrl_wr && host_ctrl_wdata[HOST_IRQ_BIT] |=> ##1 host_irq_n;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("pin not high");
  property p_burst; dma_burst |-> $past(wfifo_push) ##1 !dma_burst; endproperty
  a_burst: assert property (p_burst) else $error("bad burst");
  property p_flush; dma_flush |-> !dma_burst && !$past(wfifo_push, 2); endproperty
  a_flush: assert property (p_flush) else $error("bad flush");
  property p_ctl_own; host_ctrl_wr && own_q[1] && !host_ctrl_wdata[HOST_IRQ_BIT]
    && !(apb_wr && paddr == CTRL_OFS) |=> ##1 $stable(port_control_reg); endproperty
  a_ctl_own: assert property (p_ctl_own) else $error("ctrl taken");
  property p_adr_own; host_addr_wr && own_q[0] && !(apb_wr && paddr == ADDR_OFS)
    |=> ##1 $stable(port_address_regs); endproperty
  a_adr_own: assert property (p_adr_own) else $error("addr taken");
endmodule : port_cfg_checker
bind host_port_ownership_and_flush_ctl port_cfg_checker #(.ADDR_W(ADDR_W)) chk (
  .pclk              (pclk),
  .presetn           (presetn),
  .psel              (psel),
  .penable           (penable),
  .pwrite            (pwrite),
  .paddr             (paddr),
  .pwdata            (pwdata),
  .prdata            (prdata),
  .pready            (pready),
  .pslverr           (pslverr),
  .host_ctrl_wr      (host_ctrl_wr),
  .host_ctrl_wdata   (host_ctrl_wdata),
  .host_addr_wr      (host_addr_wr),
  .wfifo_push        (wfifo_push),
  .dma_burst         (dma_burst),
  .dma_flush         (dma_flush),
  .host_irq_n        (host_irq_n),
  .port_control_reg  (port_control_reg),
  .port_address_regs (port_address_regs)
);
`default_nettype wire

//--- tb/testbench.sv
/* Self-checking bench: APB master, host model, scoreboards.
   Assumes a zero-wait APB slave and one-cycle register views. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import port_cfg_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite;
  logic [7:0]  paddr, host_ctrl_wdata, port_control_reg;
  logic [31:0] pwdata, prdata, host_addr_wdata, port_address_regs, a1;
  logic        pready, pslverr, dma_burst, dma_flush, host_irq_n, irq;
  logic        host_ctrl_wr, host_addr_wr, wfifo_push;
  logic [31:0] exp_q[$];
  logic [1:0]  ev_q[$];
  logic        err_q[$];
  int          miscompares = 0, total_checks = 0, t, cnt;
  always #2.5 pclk = ~pclk;
  host_port_ownership_and_flush_ctl #(.ADDR_W(32)) uut (
    .pclk              (pclk),
    .presetn           (presetn),
    .psel              (psel),
    .penable           (penable),
    .pwrite            (pwrite),
    .paddr             (paddr),
    .pwdata            (pwdata),
    .prdata            (prdata),
    .pready            (pready),
    .pslverr           (pslverr),
    .host_ctrl_wr      (host_ctrl_wr),
    .host_ctrl_wdata   (host_ctrl_wdata),
    .host_addr_wr      (host_addr_wr),
    .host_addr_wdata   (host_addr_wdata),
    .wfifo_push        (wfifo_push),
    .dma_burst         (dma_burst),
    .dma_flush         (dma_flush),
    .host_irq_n        (host_irq_n),
    .port_control_reg  (port_control_reg),
    .port_address_regs (port_address_regs),
    .irq               (irq)
  );
  host_model host (
    .pclk            (pclk),
    .host_ctrl_wr    (host_ctrl_wr),
    .host_ctrl_wdata (host_ctrl_wdata),
    .host_addr_wr    (host_addr_wr),
    .host_addr_wdata (host_addr_wdata),
    .wfifo_push      (wfifo_push)
  );
  //////////////////////////////
  task automatic cmp(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, act, exp);
    end
  endtask : cmp
  task automatic summarize;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    err_q.push_back(!(a inside {CONFIG_OFS, CTRL_OFS, IRQ_STAT_OFS, IRQ_MASK_OFS,
                                STATUS_OFS, ADDR_OFS}));
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk) penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Result watcher: oldest note against each access's error flag, each read and each drain pulse
  always @(posedge pclk) begin
    if (psel && penable && pready)
      cmp(pslverr, err_q.size() ? err_q.pop_front() : 1'bx);
    if (psel && penable && pready && !pwrite)
      cmp(prdata, exp_q.size() ? exp_q.pop_front() : 'x);
    if (dma_burst || dma_flush)
      cmp({dma_burst, dma_flush}, ev_q.size() ? ev_q.pop_front() : 'x);
  end
  // Watchdog
  initial begin
    #100000;
    miscompares++;
    summarize();
  end
  // Main sequence
  initial begin
    presetn = 1'b0;
    psel    <= 1'b0;
    penable <= 1'b0;
    pwrite  <= 1'b0;
    paddr   <= 8'h00;
    pwdata  <= 32'h0;
    void'($urandom(28484));
    t = $urandom_range(40, 8);
    a1 = $urandom & 32'hffff_fffc;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(CONFIG_OFS, 32'h80);
    rd(CTRL_OFS, 32'h08);
    rd(ADDR_OFS, 32'h0);
    rd(8'h20, 32'h0);
    apb(1'b1, 8'h20, 32'hffff_ffff);
    apb(1'b1, CTRL_OFS, 32'h1);
    rd(CTRL_OFS, 32'h08);
    host.adr(a1);
    rd(ADDR_OFS, a1);
    cmp(port_address_regs, a1);
    host.ctl(8'h01);
    rd(CTRL_OFS, 32'h09);
    cmp(port_control_reg, 8'h09);
    $display("test host owner done");
    apb(1'b1, CONFIG_OFS, 32'h300 | t);
    rd(CONFIG_OFS, 32'h300 | t);
    host.adr(~a1);
    rd(ADDR_OFS, a1);
    apb(1'b1, ADDR_OFS, ~a1 & 32'hffff_fffc);
    rd(ADDR_OFS, ~a1 & 32'hffff_fffc);
    cmp(port_address_regs, ~a1 & 32'hffff_fffc);
    host.ctl(8'h00);
    rd(CTRL_OFS, 32'h09);
    apb(1'b1, CTRL_OFS, 32'h0);
    rd(CTRL_OFS, 32'h08);
    apb(1'b1, CTRL_OFS, 32'h4);
    repeat (2) @(posedge pclk);
    cmp(host_irq_n, 1'b0);
    host.ctl(8'h04);
    repeat (2) @(posedge pclk);
    cmp(host_irq_n, 1'b1);
    $display("test cpu owner done");
    ev_q.push_back(2'b10);
    host.push(4);
    repeat (4) @(posedge pclk);
    cmp(ev_q.size(), 0);
    ev_q.push_back(2'b01);
    host.push(2);
    repeat (t / 2) @(posedge pclk);
    host.push(1);
    cnt = 0;
    while (ev_q.size() != 0 && cnt < t + 30) begin
      @(posedge pclk);
      cnt++;
    end
    cmp({cnt >= t + 3, cnt <= t + 4, ev_q.size() == 0}, 3'b111);
    $display("test drain done");
    rd(IRQ_STAT_OFS, 32'h7);
    apb(1'b1, IRQ_MASK_OFS, 32'h0);
    repeat (2) @(posedge pclk);
    cmp(irq, 1'b0);
    apb(1'b1, IRQ_MASK_OFS, 32'h7);
    rd(IRQ_MASK_OFS, 32'h7);
    cmp(irq, 1'b1);
    rd(STATUS_OFS, 32'h0);
    apb(1'b1, IRQ_STAT_OFS, 32'h7);
    rd(IRQ_STAT_OFS, 32'h0);
    cmp(irq, 1'b0);
    $display("test interrupts done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
